/* File: common/sms_pkg.sv */
/*
 Package for the switch mode supervisor: mode enumeration, fault bundle,
 timing constants and register bit positions.
 Assumes a 50 MHz system clock; timeouts are in milliseconds as printed.
*/
// Behaviour
// - Wake pin rise with both supplies, or direct input rise, enters normal; the wake pin here checks neither supply.
// - Per channel, activity flag drops after 250 ms without input activity.
// - Wake-up is OR of wake pin and both activity flags; none gives sleep.
// - Fail-safe on logic supply loss when enabled, or watchdog timeout if enabled.
// - Watchdog disable sits at config bit D4; set blocks fail-safe on timeout.
// - With wake pin low or in fail-safe, only direct inputs steer channels.
// - Fault is OR of channel faults, undervoltage and gated supply-high fault.
// - Mode priority: sleep, then fault, then fail-safe, else normal.
// - Sleep after power-up; channels, serial off, registers at defaults.
// - Fail-safe entry drives indicator low and blocks serial register access.
// - Fail-safe entry delatches faults, resets registers but power-up and parallel.
// - Watchdog starts on wake pin rise and checks first bit toggles per window.
// - Leaving fail-safe needs a D15-set word, then another word within timeout.
// - Return to normal releases indicator, resets registers keeping latched fault bits.
// - Detection defaults: short-to-supply, open loads off; clock fail, overvoltage on.
// - Fault pin low in real time; sticky bit set until its register read.
// - Fault turns its channel off except open load, clock fail, short-to-supply.
// - Register read clears a fault bit only when cause gone and not latched.
// - Fault in fail-safe keeps registers reset and direct-input control.
// - Fault cleared in fail-safe returns there, no counter reset or delatch.
// - Fail-safe entered from fault mode delatches and resets registers.
package sms_pkg;
    typedef enum {SMS_SLEEP, SMS_NORMAL, SMS_FAILSAFE, SMS_FAULT} sms_mode_t;

    // Per-channel fault causes from the analog side
    typedef struct packed {
        logic overcurrent_fault;
        logic overtemp_fault;
        logic short_circuit_fault;
        logic open_load_off;
        logic open_load_on;
        logic short_to_supply;
        logic clock_fail;
    } sms_chan_fault_t;

    localparam int SMS_CLK_HZ = 50_000_000;
    localparam int WATCHDOG_TIMEOUT_MS = 310;
    localparam int INPUT_TIMEOUT_MS = 250;
    localparam int WATCHDOG_TIMEOUT_CYC = SMS_CLK_HZ / 1000 * WATCHDOG_TIMEOUT_MS;
    localparam int INPUT_TIMEOUT_CYC = SMS_CLK_HZ / 1000 * INPUT_TIMEOUT_MS;

    // global_config_register and serial word bit positions
    localparam int GCR_WATCHDOG_DISABLE_BIT = 4;
    localparam int GCR_LOGIC_LOSS_EN_BIT = 3;
    localparam int WORD_TOGGLE_BIT = 15;

    // Detection enable and configuration defaults
    localparam logic DEF_SHORT_TO_SUPPLY_EN = 1'b0;
    localparam logic DEF_OPEN_LOAD_OFF_EN = 1'b0;
    localparam logic DEF_OPEN_LOAD_ON_EN = 1'b0;
    localparam logic DEF_CLOCK_FAIL_EN = 1'b1;
    localparam logic DEF_SUPPLY_HIGH_EN = 1'b1;
    localparam logic DEF_WATCHDOG_DISABLE = 1'b0;
    localparam logic DEF_LOGIC_LOSS_EN = 1'b0;
endpackage

/* File: design/sms_timeout.sv */
/*
 Retriggerable timeout counter: restarts on kick, reports expiry as a level.
 Assumes kick and run come from the system clock domain.
*/
module sms_timeout #(
    parameter int LIMIT = 1000
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic run,
    input wire logic kick,
    output logic expired
);
    logic [31:0] count;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            count <= 32'h0;
            expired <= 1'b0;
        end else if (!run || kick) begin
            count <= 32'h0;
            expired <= 1'b0;
        end else if (count >= 32'(LIMIT - 1)) begin
            expired <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

/* File: design/sms_supervisor.sv */
/*
 Operating-mode supervisor: wake-up, fail-safe and fault terms, mode
 selection, serial watchdog, input timeouts, sticky fault bits and indicators.
 Assumes pins arrive asynchronous; serial words arrive as a one-cycle strobe
 with data from the same clock domain as SYS_CLK.
*/
module sms_supervisor
    import sms_pkg::*;
#(
    parameter int WD_CYCLES = WATCHDOG_TIMEOUT_CYC,
    parameter int IN_CYCLES = INPUT_TIMEOUT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic RESET_WAKE_PIN,
    input wire logic [1:0] DIRECT_IN,
    input wire logic LOGIC_SUPPLY_OK,
    input wire logic POWER_SUPPLY_OK,
    input wire logic WORD_VALID,
    input wire logic [15:0] WORD_DATA,
    input wire logic CFG_WRITE,
    input wire logic [15:0] CFG_DATA,
    input wire logic [1:0] SPI_ON,
    input wire logic PARALLEL_IN,
    input wire sms_pkg::sms_chan_fault_t CHAN_FAULT0,
    input wire sms_pkg::sms_chan_fault_t CHAN_FAULT1,
    input wire logic UNDERVOLTAGE_FAULT,
    input wire logic SUPPLY_HIGH_FAULT,
    input wire logic LATCHED0,
    input wire logic LATCHED1,
    input wire logic READ_FAULT0,
    input wire logic READ_FAULT1,
    output sms_pkg::sms_mode_t MODE,
    output logic NORMAL_MODE_FLAG,
    output logic FAILSAFE_INDICATOR_N_O,
    output logic FAILSAFE_INDICATOR_N_OE,
    output logic FAULT_STATUS_N,
    output logic [1:0] CHANNEL_ON,
    output logic SERIAL_ENABLE,
    output logic REG_ACCESS_OK,
    output logic REG_RESET,
    output logic DELATCH,
    output logic WATCHDOG_DISABLE,
    output logic POWER_UP_FLAG,
    output logic PARALLEL_MODE,
    output logic [6:0] STICKY0,
    output logic [6:0] STICKY1
);
    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage only feeds the second
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_d;
    logic wake;
    logic [1:0] din;
    logic logic_ok;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_d <= 4'h0;
        end else begin
            sync_a <= {LOGIC_SUPPLY_OK, DIRECT_IN, RESET_WAKE_PIN};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    assign wake = sync_b[0];
    assign din = sync_b[2:1];
    assign logic_ok = sync_b[3];

    logic wake_rise;
    logic [1:0] din_rise;
    logic [1:0] din_edge;
    assign wake_rise = sync_b[0] & ~sync_d[0];
    assign din_rise = sync_b[2:1] & ~sync_d[2:1];
    assign din_edge = sync_b[2:1] ^ sync_d[2:1];

    ////////////////////////////////////////////////////////////////////////
    // Direct input activity flags
    logic [1:0] activity;
    logic [1:0] in_expired;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_in
            // Input held high counts as activity; only a long low times out
            sms_timeout #(.LIMIT(IN_CYCLES)) u_in (
                .SYS_CLK(SYS_CLK),
                .RST(RST),
                .run(activity[g] & ~din[g]),
                .kick(din_edge[g]),
                .expired(in_expired[g])
            );
        end
    endgenerate

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            activity <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (din_rise[i] && POWER_SUPPLY_OK) begin
                    activity[i] <= 1'b1;
                end else if (in_expired[i]) begin
                    activity[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and serial watchdog
    logic logic_loss_en;
    logic logic_seen;
    logic wd_run;
    logic wd_expired;
    logic wd_kick;
    logic last_toggle;
    logic wd_timeout;
    logic supply_lost;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            WATCHDOG_DISABLE <= DEF_WATCHDOG_DISABLE;
            logic_loss_en <= DEF_LOGIC_LOSS_EN;
        end else if (REG_RESET) begin
            WATCHDOG_DISABLE <= DEF_WATCHDOG_DISABLE;
            logic_loss_en <= DEF_LOGIC_LOSS_EN;
        end else if (CFG_WRITE && REG_ACCESS_OK) begin
            WATCHDOG_DISABLE <= CFG_DATA[GCR_WATCHDOG_DISABLE_BIT];
            logic_loss_en <= CFG_DATA[GCR_LOGIC_LOSS_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            logic_seen <= 1'b0;
        end else if (logic_ok) begin
            logic_seen <= 1'b1;
        end
    end

    // Watchdog only runs once the wake pin has risen with logic supply
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wd_run <= 1'b0;
        end else if (!wake) begin
            wd_run <= 1'b0;
        end else if (wake_rise && logic_ok) begin
            wd_run <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            last_toggle <= 1'b0;
        end else if (WORD_VALID) begin
            last_toggle <= WORD_DATA[WORD_TOGGLE_BIT];
        end
    end

    assign wd_kick = WORD_VALID && (WORD_DATA[WORD_TOGGLE_BIT] != last_toggle);

    sms_timeout #(.LIMIT(WD_CYCLES)) u_wd (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .run(wd_run & ~WATCHDOG_DISABLE & (MODE == SMS_NORMAL)),
        .kick(wd_kick),
        .expired(wd_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fail-safe exit: D15 word, then another word inside the window
    logic exit_armed;
    logic exit_expired;

    sms_timeout #(.LIMIT(WD_CYCLES)) u_exit (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .run(exit_armed),
        .kick(1'b0),
        .expired(exit_expired)
    );

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wd_timeout <= 1'b0;
            supply_lost <= 1'b0;
            exit_armed <= 1'b0;
        end else begin
            if (wd_expired && !WATCHDOG_DISABLE) begin
                wd_timeout <= 1'b1;
            end else if (exit_armed && WORD_VALID) begin
                wd_timeout <= 1'b0;
            end else if (!wake) begin
                wd_timeout <= 1'b0;
            end
            // Held here since the enable bit is wiped by the fail-safe register reset
            if (logic_seen && !logic_ok && logic_loss_en) begin
                supply_lost <= 1'b1;
            end else if (logic_ok && (!wake || (exit_armed && WORD_VALID))) begin
                supply_lost <= 1'b0;
            end
            if (!(wd_timeout || supply_lost) || exit_expired || (exit_armed && WORD_VALID)) begin
                exit_armed <= 1'b0;
            end else if (WORD_VALID && WORD_DATA[WORD_TOGGLE_BIT]) begin
                exit_armed <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terms and mode selection
    logic wake_term;
    logic failsafe_term;
    logic fault_term;
    logic [1:0] chan_off;
    sms_mode_t next_mode;

    function automatic logic chan_trip(input sms_chan_fault_t f);
        // Open load, clock fail and short-to-supply leave the channel on
        return f.overcurrent_fault | f.overtemp_fault | f.short_circuit_fault;
    endfunction

    assign wake_term = wake | activity[0] | activity[1];
    assign failsafe_term = supply_lost | wd_timeout;
    assign fault_term = chan_trip(CHAN_FAULT0) | chan_trip(CHAN_FAULT1) | UNDERVOLTAGE_FAULT
        | (SUPPLY_HIGH_FAULT & DEF_SUPPLY_HIGH_EN);

    always_comb begin
        if (!wake_term) begin
            next_mode = SMS_SLEEP;
        end else if (fault_term) begin
            next_mode = SMS_FAULT;
        end else if (failsafe_term) begin
            next_mode = SMS_FAILSAFE;
        end else begin
            next_mode = SMS_NORMAL;
        end
    end

    logic failsafe_q;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            MODE <= SMS_SLEEP;
            failsafe_q <= 1'b0;
        end else begin
            MODE <= next_mode;
            failsafe_q <= wake_term & failsafe_term;
        end
    end

    logic fs_enter;
    logic fs_leave;
    assign fs_enter = wake_term & failsafe_term & ~failsafe_q;
    assign fs_leave = failsafe_q & ~failsafe_term & wake_term;

    ////////////////////////////////////////////////////////////////////////
    // Outputs, register reset and delatch pulses
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            NORMAL_MODE_FLAG <= 1'b0;
            FAILSAFE_INDICATOR_N_O <= 1'b0;
            FAILSAFE_INDICATOR_N_OE <= 1'b0;
            FAULT_STATUS_N <= 1'b1;
            SERIAL_ENABLE <= 1'b0;
            REG_ACCESS_OK <= 1'b0;
            REG_RESET <= 1'b1;
            DELATCH <= 1'b0;
        end else begin
            NORMAL_MODE_FLAG <= (next_mode == SMS_NORMAL);
            FAILSAFE_INDICATOR_N_O <= 1'b0;
            FAILSAFE_INDICATOR_N_OE <= wake_term & failsafe_term;
            FAULT_STATUS_N <= ~fault_term;
            SERIAL_ENABLE <= wake_term;
            REG_ACCESS_OK <= wake_term & ~failsafe_term & wake;
            // Registers held reset in sleep and throughout fail-safe
            REG_RESET <= ~wake_term | fs_enter | fs_leave | (wake_term & failsafe_term);
            DELATCH <= fs_enter;
        end
    end

    // Power-up and parallel bits survive every mode-change reset
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            POWER_UP_FLAG <= 1'b1;
            PARALLEL_MODE <= 1'b0;
        end else begin
            if (READ_FAULT0) begin
                POWER_UP_FLAG <= 1'b0;
            end
            if (CFG_WRITE && REG_ACCESS_OK) begin
                PARALLEL_MODE <= PARALLEL_IN;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CHANNEL_ON <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (next_mode == SMS_SLEEP || UNDERVOLTAGE_FAULT || SUPPLY_HIGH_FAULT) begin
                    CHANNEL_ON[i] <= 1'b0;
                end else if (chan_trip(i == 0 ? CHAN_FAULT0 : CHAN_FAULT1)) begin
                    CHANNEL_ON[i] <= 1'b0;
                end else if (!wake || failsafe_term) begin
                    CHANNEL_ON[i] <= din[i];
                end else begin
                    CHANNEL_ON[i] <= din[i] | SPI_ON[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky fault bits
    function automatic logic [6:0] sticky_next(input logic [6:0] cur, input sms_chan_fault_t f,
                                               input logic rd, input logic latched, input logic clr);
        logic [6:0] cause;
        cause = {f.overcurrent_fault, f.overtemp_fault, f.short_circuit_fault, f.open_load_off & DEF_OPEN_LOAD_OFF_EN,
                 f.open_load_on & DEF_OPEN_LOAD_ON_EN, f.short_to_supply & DEF_SHORT_TO_SUPPLY_EN,
                 f.clock_fail & DEF_CLOCK_FAIL_EN};
        // Set wins over clear; read clears only vanished, unlatched causes
        if (clr) begin
            return latched ? (cur & 7'h70) | cause : cause;
        end else if (rd && !latched) begin
            return cause;
        end
        return cur | cause;
    endfunction

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            STICKY0 <= 7'h00;
            STICKY1 <= 7'h00;
        end else begin
            STICKY0 <= sticky_next(STICKY0, CHAN_FAULT0, READ_FAULT0, LATCHED0, fs_leave);
            STICKY1 <= sticky_next(STICKY1, CHAN_FAULT1, READ_FAULT1, LATCHED1, fs_leave);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_sleep_no_wake: assert property (@(posedge SYS_CLK) disable iff (RST)
        !wake_term |=> MODE == SMS_SLEEP) else $error("no wake-up but not asleep");
    chk_fault_priority: assert property (@(posedge SYS_CLK) disable iff (RST)
        wake_term && fault_term |=> MODE == SMS_FAULT) else $error("fault not selected");
    chk_fs_indicator: assert property (@(posedge SYS_CLK) disable iff (RST)
        wake_term && failsafe_term |=> FAILSAFE_INDICATOR_N_OE) else $error("indicator not driven");
    chk_fs_delatch: assert property (@(posedge SYS_CLK) disable iff (RST)
        fs_enter |=> DELATCH && REG_RESET) else $error("no delatch on fail-safe entry");
    chk_fault_pin: assert property (@(posedge SYS_CLK) disable iff (RST)
        fault_term |=> !FAULT_STATUS_N) else $error("fault pin not low");
    chk_wd_disable: assert property (@(posedge SYS_CLK) disable iff (RST)
        WATCHDOG_DISABLE && !wd_timeout |=> !wd_timeout) else $error("timeout while disabled");
    chk_access_block: assert property (@(posedge SYS_CLK) disable iff (RST)
        failsafe_term |=> !REG_ACCESS_OK) else $error("access in fail-safe");
    chk_direct_only: assert property (@(posedge SYS_CLK) disable iff (RST)
        wake_term && !wake && !fault_term && !UNDERVOLTAGE_FAULT && !SUPPLY_HIGH_FAULT
        |=> CHANNEL_ON == $past(din)) else $error("channel not from direct input");
    chk_exit_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
        exit_armed && WORD_VALID && logic_ok && !wd_expired |=> !wd_timeout && !supply_lost)
        else $error("fail-safe cause kept after exit word");
endmodule

/* File: test/sms_host_model.sv */
/*
 Host model: sends serial words with a flipping bit 15 and can run a direct
 input as a free link clock. Assumes the bench resets it with the supervisor.
*/
module sms_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic keep_alive,
    input wire logic link_run,
    output logic word_valid,
    output logic [15:0] word_data,
    output logic link_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] gap;
    logic tgl;

    ////////////////////////////////////////////////////////////////////////
    // Toggles every 80 ns, 3 ns before a clk rise; parked low outside bursts
    initial begin
        link_in = 1'b0;
        #7;
        forever begin
            #80;
            link_in = link_run ? ~link_in : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One word every 8 cycles, well inside any watchdog window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap <= 3'h0;
            tgl <= 1'b1;
            word_valid <= 1'b0;
            word_data <= 16'h0000;
        end else begin
            gap <= gap + 3'h1;
            word_valid <= keep_alive && gap == 3'h7;
            // Idle data keeps moving so nothing reads a stale word
            word_data <= ~word_data;
            if (keep_alive && gap == 3'h7) begin
                word_data <= {tgl, 15'h1a5c};
                tgl <= ~tgl;
            end else if (!keep_alive) begin
                tgl <= 1'b1; // First word after a pause has bit 15 set
            end
        end
    end
endmodule

/* File: test/tb.sv */
/*
 Self-checking bench for the mode supervisor with the host model in front.
 Assumes shortened watchdog and input timeouts set by parameter here.
*/
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sms_pkg::*;

    localparam int WD = 60;
    localparam int IN = 30;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic [1:0] din = 2'b00;
    logic ls_ok = 1'b1;
    logic cfg_write = 1'b0;
    logic [15:0] cfg_data = 16'h0000;
    logic [1:0] spi_on = 2'b00;
    logic par_in = 1'b0;
    sms_chan_fault_t f0 = '0;
    sms_chan_fault_t f1 = '0;
    logic uv = 1'b0;
    logic sh = 1'b0;
    logic lat1 = 1'b0;
    logic rd_f1 = 1'b0;
    logic keep = 1'b0;
    logic link_run = 1'b0;
    logic link_in;
    logic word_valid;
    logic [15:0] word_data;
    sms_mode_t mode;
    logic nm, fs_o, fs_oe, fault_n, ser_en, reg_ok, reg_rst, delatch, watchdog_disable, pup, par;
    logic [1:0] chan_on;
    logic [6:0] st0;
    logic [6:0] st1;
    int fails = 0;
    int total_checks = 0;
    int dl_cnt = 0;
    // Open-drain indicator with its external pull-up
    wire fs_pin = fs_oe ? fs_o : 1'b1;

    sms_supervisor #(.WD_CYCLES(WD), .IN_CYCLES(IN)) i_dut (
        .SYS_CLK(clk), .RST(rst), .RESET_WAKE_PIN(wake), .DIRECT_IN(din | {link_in, 1'b0}),
        .LOGIC_SUPPLY_OK(ls_ok), .POWER_SUPPLY_OK(1'b1), .WORD_VALID(word_valid),
        .WORD_DATA(word_data), .CFG_WRITE(cfg_write), .CFG_DATA(cfg_data), .SPI_ON(spi_on),
        .PARALLEL_IN(par_in), .CHAN_FAULT0(f0), .CHAN_FAULT1(f1), .UNDERVOLTAGE_FAULT(uv),
        .SUPPLY_HIGH_FAULT(sh), .LATCHED0(1'b0), .LATCHED1(lat1), .READ_FAULT0(1'b0),
        .READ_FAULT1(rd_f1), .MODE(mode), .NORMAL_MODE_FLAG(nm), .FAILSAFE_INDICATOR_N_O(fs_o),
        .FAILSAFE_INDICATOR_N_OE(fs_oe), .FAULT_STATUS_N(fault_n), .CHANNEL_ON(chan_on),
        .SERIAL_ENABLE(ser_en), .REG_ACCESS_OK(reg_ok), .REG_RESET(reg_rst), .DELATCH(delatch),
        .WATCHDOG_DISABLE(watchdog_disable), .POWER_UP_FLAG(pup), .PARALLEL_MODE(par), .STICKY0(st0),
        .STICKY1(st1));

    sms_host i_host (.clk(clk), .rst(rst), .keep_alive(keep), .link_run(link_run),
        .word_valid(word_valid), .word_data(word_data), .link_in(link_in));

    always #10 clk = ~clk;
    always @(posedge clk) if (delatch === 1'b1) dl_cnt++;

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_mode(input sms_mode_t m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) cyc(1);
        chk("mode", 16'(m), 16'(mode));
        if (mode !== m) test_done();
    endtask

    task automatic wr_cfg(input logic [15:0] d, input logic p);
        @(posedge clk);
        cfg_write <= 1'b1;
        cfg_data <= d;
        par_in <= p;
        @(posedge clk);
        cfg_write <= 1'b0;
        cyc(2);
    endtask

    task automatic read1();
        @(posedge clk);
        rd_f1 <= 1'b1;
        @(posedge clk);
        rd_f1 <= 1'b0;
        cyc(2);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("mode", 16'(SMS_SLEEP), 16'(mode));
        chk("chan_on", 16'h0, 16'(chan_on));
        chk("ser_en", 16'h0, 16'(ser_en));
        chk("reg_rst", 16'h1, 16'(reg_rst));
        chk("fs_pin", 16'h1, 16'(fs_pin));
        $display("done reset");
    endtask

    task automatic t_wake();
        @(posedge clk);
        wake <= 1'b1;
        keep <= 1'b1;
        wait_mode(SMS_NORMAL, 8);
        chk("nm", 16'h1, 16'(nm));
        chk("reg_ok", 16'h1, 16'(reg_ok));
        chk("ser_en", 16'h1, 16'(ser_en));
        wr_cfg(16'h0000, 1'b1);
        chk("par", 16'h1, 16'(par));
        cyc(3 * WD);
        chk("mode", 16'(SMS_NORMAL), 16'(mode));
        $display("done wake");
    endtask

    task automatic t_faults();
        @(posedge clk);
        spi_on <= 2'b11;
        f0.open_load_on <= 1'b1;
        cyc(4);
        chk("mode", 16'(SMS_NORMAL), 16'(mode));
        chk("chan_on", 16'h3, 16'(chan_on));
        f0 <= '0;
        f1.overtemp_fault <= 1'b1;
        wait_mode(SMS_FAULT, 4);
        chk("fault_n", 16'h0, 16'(fault_n));
        chk("chan_on", 16'h1, 16'(chan_on));
        f1 <= '0;
        wait_mode(SMS_NORMAL, 4);
        chk("fault_n", 16'h1, 16'(fault_n));
        chk("st1", 16'h20, 16'(st1));
        lat1 <= 1'b1;
        read1();
        chk("st1", 16'h20, 16'(st1));
        lat1 <= 1'b0;
        read1();
        chk("st1", 16'h0, 16'(st1));
        uv <= 1'b1;
        wait_mode(SMS_FAULT, 4);
        chk("chan_on", 16'h0, 16'(chan_on));
        uv <= 1'b0;
        sh <= 1'b1;
        cyc(2);
        wait_mode(SMS_FAULT, 4);
        sh <= 1'b0;
        spi_on <= 2'b10;
        wait_mode(SMS_NORMAL, 4);
        $display("done faults");
    endtask

    task automatic t_timeout();
        int dl0;
        dl0 = dl_cnt;
        @(posedge clk);
        keep <= 1'b0;
        cyc(WD - 12);
        chk("mode", 16'(SMS_NORMAL), 16'(mode));
        wait_mode(SMS_FAILSAFE, 30);
        chk("fs_pin", 16'h0, 16'(fs_pin));
        chk("reg_ok", 16'h0, 16'(reg_ok));
        chk("reg_rst", 16'h1, 16'(reg_rst));
        chk("delatch", 16'h1, 16'(delatch));
        chk("par", 16'h1, 16'(par));
        chk("pup", 16'h1, 16'(pup));
        wr_cfg(16'h0010, 1'b0);
        chk("delatch_cnt", 16'h1, 16'(dl_cnt - dl0));
        chk("watchdog_disable", 16'h0, 16'(watchdog_disable));
        din <= 2'b01;
        cyc(6);
        chk("chan_on", 16'h1, 16'(chan_on));
        f0.overcurrent_fault <= 1'b1;
        wait_mode(SMS_FAULT, 4);
        chk("fault_n", 16'h0, 16'(fault_n));
        chk("reg_ok", 16'h0, 16'(reg_ok));
        f0 <= '0;
        wait_mode(SMS_FAILSAFE, 4);
        chk("st0", 16'h40, 16'(st0));
        chk("fault_n", 16'h1, 16'(fault_n));
        chk("reg_rst", 16'h1, 16'(reg_rst));
        din <= 2'b00;
        keep <= 1'b1;
        wait_mode(SMS_NORMAL, 40);
        chk("fs_pin", 16'h1, 16'(fs_pin));
        chk("st0", 16'h0, 16'(st0));
        chk("par", 16'h1, 16'(par));
        $display("done timeout");
    endtask

    task automatic t_disable();
        wr_cfg(16'h0018, 1'b1);
        chk("watchdog_disable", 16'h1, 16'(watchdog_disable));
        keep <= 1'b0;
        cyc(3 * WD);
        chk("mode", 16'(SMS_NORMAL), 16'(mode));
        ls_ok <= 1'b0;
        wait_mode(SMS_FAILSAFE, 10);
        cyc(1);
        chk("mode", 16'(SMS_FAILSAFE), 16'(mode));
        chk("watchdog_disable", 16'h0, 16'(watchdog_disable));
        ls_ok <= 1'b1;
        keep <= 1'b1;
        wait_mode(SMS_NORMAL, 40);
        $display("done disable");
    endtask

    task automatic t_sleep();
        @(posedge clk);
        wake <= 1'b0;
        din <= 2'b10;
        cyc(4);
        din <= 2'b00;
        cyc(IN - 8);
        chk("mode", 16'(SMS_NORMAL), 16'(mode));
        wait_mode(SMS_SLEEP, 20);
        chk("chan_on", 16'h0, 16'(chan_on));
        keep <= 1'b0;
        ls_ok <= 1'b0;
        link_run <= 1'b1;
        wait_mode(SMS_NORMAL, 20);
        link_run <= 1'b0;
        wait_mode(SMS_SLEEP, IN + 30);
        $display("done sleep");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_wake();
        t_faults();
        t_timeout();
        t_disable();
        t_sleep();
        test_done();
    end
endmodule
